// ===== design/sbp_sector_block_protect.sv
// Decided for this implementation: the address map and the AXI4-Lite slave port.
`timescale 1ns/1ps
module sbp_sector_block_protect #(
	parameter int PROG_CYCLES = sbp_pkg::PROG_CYCLES,
	parameter int ERASE_CYCLES = sbp_pkg::ERASE_CYCLES
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic busy,
	output logic array_write_grant,
	output logic array_read_grant
);
	localparam int NB = sbp_pkg::NUM_BLK;
	localparam int CW = sbp_pkg::CNT_W;

	// protected unless both bits are 1
	function automatic logic is_protected(input logic pers, input logic vol);
		return !(pers && vol);
	endfunction : is_protected

	function automatic logic is_mapped(input logic [7:0] a);
		return a == sbp_pkg::REG_CMD || a == sbp_pkg::REG_ADDR ||
			a == sbp_pkg::REG_STATUS || a == sbp_pkg::REG_BLOCK;
	endfunction : is_mapped

	// factory state, never touched by reset
	logic [NB-1:0] persistent_protect_bit = sbp_pkg::ERASED_PERS;
	logic [NB-1:0] volatile_protect_bit;
	logic persistent_bit_lock;
	sbp_pkg::sbp_state_type state, next_state;
	logic [CW-1:0] cnt, next_cnt;
	logic [7:0] aw_q;
	logic [31:0] wdata_q, rd_word, clr_bits;
	logic [3:0] wstrb_q, cmd_op;
	logic [sbp_pkg::ADDR_W-1:0] addr_reg;
	logic [sbp_pkg::BLK_W-1:0] blk, tgt_blk;
	logic wr_fire, cmd_go, cmd_val, idle_go, pers_rd;
	logic prot_err, lock_err, busy_err, verify_err;

	// block index of the address register
	assign blk = addr_reg[sbp_pkg::BLK_LSB +: sbp_pkg::BLK_W];
	assign idle_go = cmd_go && state == sbp_pkg::SBP_IDLE;
	assign wr_fire = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;

	// write channels: take address and data in either order
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= sbp_pkg::RESP_OKAY;
			aw_q <= 8'h00;
			wdata_q <= 32'h00000000;
			wstrb_q <= 4'h0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				s_axi_awready <= 1'b0;
				aw_q <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				s_axi_wready <= 1'b0;
				wdata_q <= s_axi_wdata;
				wstrb_q <= s_axi_wstrb;
			end
			if (wr_fire) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= is_mapped(aw_q) ? sbp_pkg::RESP_OKAY :
					sbp_pkg::RESP_SLVERR;
			end
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready <= 1'b1;
			end
		end
	end

	// register writes: address, command strobe
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			addr_reg <= '0;
			cmd_go <= 1'b0;
			cmd_op <= 4'h0;
			cmd_val <= 1'b0;
		end else begin
			cmd_go <= wr_fire && aw_q == sbp_pkg::REG_CMD && wstrb_q[0];
			if (wr_fire && aw_q == sbp_pkg::REG_CMD && wstrb_q[0]) begin
				cmd_op <= wdata_q[sbp_pkg::CMD_OP_LSB +: sbp_pkg::CMD_OP_W];
				cmd_val <= wdata_q[sbp_pkg::CMD_VAL_BIT];
			end
			if (wr_fire && aw_q == sbp_pkg::REG_ADDR) begin
				for (int i = 0; i < sbp_pkg::ADDR_W; i++) begin
					if (wstrb_q[i / 8]) addr_reg[i] <= wdata_q[i];
				end
			end
		end
	end

	// status readback and block readback
	always_comb begin
		rd_word = 32'h00000000;
		unique case (s_axi_araddr)
			sbp_pkg::REG_ADDR: rd_word[sbp_pkg::ADDR_W-1:0] = addr_reg;
			sbp_pkg::REG_STATUS: begin
				rd_word[sbp_pkg::ST_BUSY] = busy;
				rd_word[sbp_pkg::ST_LOCK] = persistent_bit_lock;
				rd_word[sbp_pkg::ST_PROT_ERR] = prot_err;
				rd_word[sbp_pkg::ST_LOCK_ERR] = lock_err;
				rd_word[sbp_pkg::ST_BUSY_ERR] = busy_err;
				rd_word[sbp_pkg::ST_VERIFY_ERR] = verify_err;
				rd_word[sbp_pkg::ST_PERS_RD] = pers_rd;
			end
			sbp_pkg::REG_BLOCK: begin
				rd_word[sbp_pkg::BK_PERS] = persistent_protect_bit[blk];
				rd_word[sbp_pkg::BK_VOL] = volatile_protect_bit[blk];
				rd_word[sbp_pkg::BK_PROT] = is_protected(
					persistent_protect_bit[blk], volatile_protect_bit[blk]);
			end
			default: rd_word = 32'h00000000;
		endcase
	end

	// read channel
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= sbp_pkg::RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= rd_word;
			s_axi_rresp <= is_mapped(s_axi_araddr) ? sbp_pkg::RESP_OKAY :
				sbp_pkg::RESP_SLVERR;
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end

	// persistent bit sequencer
	always_comb begin
		next_state = state;
		next_cnt = cnt;
		unique case (state)
			sbp_pkg::SBP_IDLE: begin
				if (idle_go && persistent_bit_lock) begin
					if (cmd_op == sbp_pkg::OP_PERS_PROG) begin
						next_state = sbp_pkg::SBP_PROG;
						next_cnt = CW'(PROG_CYCLES - 1);
					end else if (cmd_op == sbp_pkg::OP_PERS_ERASE) begin
						next_state = sbp_pkg::SBP_PRE;
						next_cnt = CW'(PROG_CYCLES - 1);
					end
				end
			end
			sbp_pkg::SBP_PROG: begin
				next_cnt = cnt - 1'b1;
				if (cnt == '0) next_state = sbp_pkg::SBP_IDLE;
			end
			sbp_pkg::SBP_PRE: begin
				next_cnt = cnt - 1'b1;
				if (cnt == '0) begin
					next_state = sbp_pkg::SBP_ERASE;
					next_cnt = CW'(ERASE_CYCLES - 1);
				end
			end
			sbp_pkg::SBP_ERASE: begin
				next_cnt = cnt - 1'b1;
				if (cnt == '0) next_state = sbp_pkg::SBP_VERIFY;
			end
			sbp_pkg::SBP_VERIFY: next_state = sbp_pkg::SBP_IDLE;
			default: next_state = sbp_pkg::SBP_IDLE;
		endcase
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			state <= sbp_pkg::SBP_IDLE;
			cnt <= '0;
			busy <= 1'b0;
			tgt_blk <= '0;
		end else begin
			state <= next_state;
			cnt <= next_cnt;
			busy <= next_state != sbp_pkg::SBP_IDLE;
			if (idle_go) tgt_blk <= blk;
		end
	end

	// persistent bits: no reset, survive it
	always_ff @(posedge clk) begin
		if (state == sbp_pkg::SBP_PROG && cnt == '0) begin
			persistent_protect_bit[tgt_blk] <= 1'b0;
		end else if (state == sbp_pkg::SBP_PRE && cnt == '0) begin
			persistent_protect_bit <= '0;
		end else if (state == sbp_pkg::SBP_ERASE && cnt == '0) begin
			persistent_protect_bit <= sbp_pkg::ERASED_PERS;
		end
	end

	// volatile bits, lock, readback bit
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			volatile_protect_bit <= sbp_pkg::RST_VOL;
			persistent_bit_lock <= sbp_pkg::RST_LOCK;
			pers_rd <= sbp_pkg::RST_PERS_RD;
		end else if (idle_go) begin
			if (cmd_op == sbp_pkg::OP_VOL_WRITE) begin
				volatile_protect_bit[blk] <= cmd_val;
			end
			if (cmd_op == sbp_pkg::OP_LOCK_CLEAR) persistent_bit_lock <= 1'b0;
			if (cmd_op == sbp_pkg::OP_PERS_READ) begin
				pers_rd <= persistent_protect_bit[blk];
			end
		end
	end

	// array grants, refused when busy; write grant also refused when protected
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			array_write_grant <= 1'b0;
			array_read_grant <= 1'b0;
		end else begin
			array_write_grant <= idle_go && (cmd_op == sbp_pkg::OP_ARRAY_PROG ||
				cmd_op == sbp_pkg::OP_ARRAY_ERASE) &&
				!is_protected(persistent_protect_bit[blk],
				volatile_protect_bit[blk]);
			array_read_grant <= idle_go &&
				cmd_op == sbp_pkg::OP_ARRAY_READ;
		end
	end

	// sticky errors, write 1 to clear, set wins
	assign clr_bits = (wr_fire && aw_q == sbp_pkg::REG_STATUS &&
		wstrb_q[0]) ? wdata_q : 32'h00000000;
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			prot_err <= 1'b0;
			lock_err <= 1'b0;
			busy_err <= 1'b0;
			verify_err <= 1'b0;
		end else begin
			prot_err <= (prot_err && !clr_bits[sbp_pkg::ST_PROT_ERR]) ||
				(idle_go && (cmd_op == sbp_pkg::OP_ARRAY_PROG ||
				cmd_op == sbp_pkg::OP_ARRAY_ERASE) &&
				is_protected(persistent_protect_bit[blk],
				volatile_protect_bit[blk]));
			lock_err <= (lock_err && !clr_bits[sbp_pkg::ST_LOCK_ERR]) ||
				(idle_go && !persistent_bit_lock &&
				(cmd_op == sbp_pkg::OP_PERS_PROG ||
				cmd_op == sbp_pkg::OP_PERS_ERASE));
			busy_err <= (busy_err && !clr_bits[sbp_pkg::ST_BUSY_ERR]) ||
				(cmd_go && state != sbp_pkg::SBP_IDLE);
			verify_err <= (verify_err && !clr_bits[sbp_pkg::ST_VERIFY_ERR]) ||
				(state == sbp_pkg::SBP_VERIFY &&
				persistent_protect_bit != sbp_pkg::ERASED_PERS);
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);

	sequence erase_start_s;
		idle_go && cmd_op == sbp_pkg::OP_PERS_ERASE && persistent_bit_lock;
	endsequence
	sequence erase_walk_s;
		state == sbp_pkg::SBP_PRE;
	endsequence

	locked_reject_a: assert property (idle_go && !persistent_bit_lock &&
		cmd_op == sbp_pkg::OP_PERS_PROG |=> state == sbp_pkg::SBP_IDLE
		##1 $stable(persistent_protect_bit) && lock_err)
		else $error("locked program changed state");
	prog_clears_a: assert property (state == sbp_pkg::SBP_PROG &&
		cnt == '0 |=> !persistent_protect_bit[$past(tgt_blk)] &&
		state == sbp_pkg::SBP_IDLE)
		else $error("program did not clear bit");
	erase_fills_a: assert property (state == sbp_pkg::SBP_ERASE &&
		cnt == '0 |=> persistent_protect_bit == sbp_pkg::ERASED_PERS)
		else $error("erase did not set all bits");
	preprog_first_a: assert property (erase_start_s |=> erase_walk_s)
		else $error("erase skipped preprogram");
	no_read_busy_a: assert property (state == sbp_pkg::SBP_PROG &&
		cmd_go |=> !array_read_grant && busy_err)
		else $error("array read granted while programming");
	pers_read_a: assert property (idle_go &&
		cmd_op == sbp_pkg::OP_PERS_READ |=>
		pers_rd == $past(persistent_protect_bit[blk]))
		else $error("persistent read wrong");
	busy_flag_a: assert property ($rose(state == sbp_pkg::SBP_PROG) |->
		busy ##1 busy)
		else $error("busy not shown");
	vol_write_a: assert property (idle_go &&
		cmd_op == sbp_pkg::OP_VOL_WRITE |=>
		volatile_protect_bit[$past(blk)] == $past(cmd_val))
		else $error("volatile write lost");
	protect_refuse_a: assert property (idle_go &&
		cmd_op == sbp_pkg::OP_ARRAY_PROG && !persistent_protect_bit[blk]
		|=> !array_write_grant && prot_err)
		else $error("write to protected block granted");
endmodule : sbp_sector_block_protect

// ===== design/sbp_pkg.sv
package sbp_pkg;
	// array geometry: 256KB blocks, 4KB sectors
	localparam int ADDR_W = 25;
	localparam int BLK_LSB = 18;
	localparam int BLK_W = 7;
	localparam int NUM_BLK = 128;
	localparam int SECT_PER_BLK = 64;
	localparam int SECT_LSB = 12;
	// register byte offsets
	localparam logic [7:0] REG_CMD = 8'h00;
	localparam logic [7:0] REG_ADDR = 8'h04;
	localparam logic [7:0] REG_STATUS = 8'h08;
	localparam logic [7:0] REG_BLOCK = 8'h0C;
	// command field and opcodes
	localparam int CMD_OP_LSB = 0;
	localparam int CMD_OP_W = 4;
	localparam int CMD_VAL_BIT = 8;
	localparam logic [3:0] OP_PERS_PROG = 4'h1;
	localparam logic [3:0] OP_PERS_ERASE = 4'h2;
	localparam logic [3:0] OP_VOL_WRITE = 4'h3;
	localparam logic [3:0] OP_PERS_READ = 4'h4;
	localparam logic [3:0] OP_LOCK_CLEAR = 4'h5;
	localparam logic [3:0] OP_ARRAY_PROG = 4'h6;
	localparam logic [3:0] OP_ARRAY_ERASE = 4'h7;
	localparam logic [3:0] OP_ARRAY_READ = 4'h8;
	// status bit positions
	localparam int ST_BUSY = 0;
	localparam int ST_LOCK = 1;
	localparam int ST_PROT_ERR = 2;
	localparam int ST_LOCK_ERR = 3;
	localparam int ST_BUSY_ERR = 4;
	localparam int ST_VERIFY_ERR = 5;
	localparam int ST_PERS_RD = 6;
	// block register bit positions
	localparam int BK_PERS = 0;
	localparam int BK_VOL = 1;
	localparam int BK_PROT = 2;
	// reset values, erased persistent value
	localparam logic RST_LOCK = 1'b1;
	localparam logic [NUM_BLK-1:0] RST_VOL = '1;
	localparam logic [NUM_BLK-1:0] ERASED_PERS = '1;
	localparam logic RST_PERS_RD = 1'b1;
	// timing
	localparam int CLK_PERIOD_NS = 25;
	localparam int PROG_TIME_NS = 200000;
	localparam int ERASE_TIME_NS = 45000000;
	localparam int PROG_CYCLES = PROG_TIME_NS / CLK_PERIOD_NS;
	localparam int ERASE_CYCLES = ERASE_TIME_NS / CLK_PERIOD_NS;
	localparam int CNT_W = 21;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	typedef enum logic [2:0] {
		SBP_IDLE = 3'h0,
		SBP_PROG = 3'h4,
		SBP_PRE = 3'h1,
		SBP_ERASE = 3'h3,
		SBP_VERIFY = 3'h2
	} sbp_state_type;
endpackage : sbp_pkg

// ===== verif/sbp_host_model.sv
`timescale 1ns/1ps
// register-bus master standing in for the host controller
module sbp_host_model (
	input wire logic clk,
	output logic [7:0] s_axi_awaddr,
	output logic s_axi_awvalid,
	input wire logic s_axi_awready,
	output logic [31:0] s_axi_wdata,
	output logic [3:0] s_axi_wstrb,
	output logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	output logic s_axi_bready,
	output logic [7:0] s_axi_araddr,
	output logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0] s_axi_rresp,
	input wire logic s_axi_rvalid,
	output logic s_axi_rready
);
	// bus idle at time zero
	initial begin
		{s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb} = '0;
		{s_axi_wvalid, s_axi_bready, s_axi_araddr} = '0;
		{s_axi_arvalid, s_axi_rready} = '0;
	end
	// each channel held until its own handshake edge
	task automatic wr(input logic [7:0] a, input logic [31:0] d,
		output logic [1:0] r);
		logic done;
		done = 1'b0;
		@(posedge clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_wstrb <= 4'hF;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (!done) begin
			@(posedge clk);
			if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid && s_axi_bready) begin
				r = s_axi_bresp;
				s_axi_bready <= 1'b0;
				done = 1'b1;
			end
		end
	endtask : wr
	// read: data and response taken at the rvalid edge
	task automatic rd(input logic [7:0] a, output logic [31:0] d,
		output logic [1:0] r);
		logic done;
		done = 1'b0;
		@(posedge clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		while (!done) begin
			@(posedge clk);
			if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid && s_axi_rready) begin
				d = s_axi_rdata;
				r = s_axi_rresp;
				s_axi_rready <= 1'b0;
				done = 1'b1;
			end
		end
	endtask : rd
endmodule : sbp_host_model

// ===== verif/tb_top.sv
`timescale 1ns/1ps
// self-checking bench for the block protection logic
module tb_top;
	localparam int PC = 24;
	localparam int EC = 40;
	logic clk = 1'b0;
	logic sys_rst = 1'b1;
	logic [7:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, rd_d;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic s_axi_rvalid, s_axi_rready, busy;
	logic array_write_grant, array_read_grant;
	logic [31:0] seed = 32'h00016AFF;
	logic pers [128];
	logic vol [128];
	logic lock, pe, le, be, prd;
	int err_count = 0;
	int n_tests = 0;
	int wg = 0;
	int rg = 0;
	int bcnt = 0;
	int brun = 0;

	always #12.5 clk = ~clk;

	sbp_sector_block_protect #(.PROG_CYCLES(PC), .ERASE_CYCLES(EC))
		sbp_sector_block_protect_inst (.*);
	sbp_host_model sbp_host_model_inst (.*);

	// grant pulse counts and length of the last busy stretch
	always @(posedge clk) begin
		if (array_write_grant === 1'b1) wg++;
		if (array_read_grant === 1'b1) rg++;
		if (busy === 1'b1) bcnt++;
		else if (bcnt != 0) begin
			brun = bcnt;
			bcnt = 0;
		end
	end

	function automatic logic [31:0] lfsr(input logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction : lfsr

	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			err_count++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : cmp

	task automatic end_of_test;
		if (err_count == 0 && n_tests > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : end_of_test

	task automatic w(input logic [7:0] a, input logic [31:0] d);
		sbp_host_model_inst.wr(a, d, rsp);
	endtask : w

	task automatic r(input logic [7:0] a);
		sbp_host_model_inst.rd(a, rd_d, rsp);
	endtask : r

	// block base address, high bits zero, then one command
	task automatic cmd(input int b, input logic [3:0] op, input logic v);
		w(sbp_pkg::REG_ADDR, 32'(b) << sbp_pkg::BLK_LSB);
		w(sbp_pkg::REG_CMD, {23'h0, v, 4'h0, op});
		repeat (2) @(posedge clk);
	endtask : cmd

	task automatic chk_blk(input int b);
		w(sbp_pkg::REG_ADDR, 32'(b) << sbp_pkg::BLK_LSB);
		r(sbp_pkg::REG_BLOCK);
		cmp(rd_d, {29'h0, !(pers[b] && vol[b]), vol[b], pers[b]});
	endtask : chk_blk

	task automatic chk_st;
		r(sbp_pkg::REG_STATUS);
		cmp(rd_d & 32'h7F, {25'h0, prd, 1'b0, be, le, pe, lock, 1'b0});
	endtask : chk_st

	task automatic do_reset;
		sys_rst <= 1'b1;
		repeat (6) @(posedge clk);
		sys_rst <= 1'b0;
		foreach (vol[i]) vol[i] = 1'b1;
		{lock, pe, le, be} = 4'h8;
		prd = sbp_pkg::RST_PERS_RD;
	endtask : do_reset

	// hang guard
	initial begin
		repeat (20000) @(posedge clk);
		err_count++;
		end_of_test;
	end

	initial begin
		int b, c, c0;
		foreach (pers[i]) pers[i] = 1'b1;
		do_reset;
		seed = lfsr(lfsr(seed));
		b = int'(seed[6:0]);
		c = (b + 1) % 128;
		chk_blk(b);
		chk_st;
		// unmapped offsets refused
		r(8'h10);
		cmp(32'(rsp), 32'(sbp_pkg::RESP_SLVERR));
		cmp(rd_d, 32'h0);
		w(8'h14, seed);
		cmp(32'(rsp), 32'(sbp_pkg::RESP_SLVERR));
		// protect, refused array writes, unprotect, granted writes
		for (int v = 0; v < 2; v++) begin
			cmd(b, sbp_pkg::OP_VOL_WRITE, v[0]);
			vol[b] = v[0];
			chk_blk(b);
			c0 = wg;
			cmd(b, sbp_pkg::OP_ARRAY_PROG, 1'b0);
			cmd(b, sbp_pkg::OP_ARRAY_ERASE, 1'b0);
			cmp(wg - c0, v * 2);
			if (v == 0) pe = 1'b1;
		end
		chk_st;
		w(sbp_pkg::REG_STATUS, 32'h0000003C);
		pe = 1'b0;
		c0 = rg;
		cmd(b, sbp_pkg::OP_ARRAY_READ, 1'b0);
		cmp(rg - c0, 1);
		// persistent program with lock open, array read while busy
		cmd(b, sbp_pkg::OP_PERS_PROG, 1'b0);
		cmp(32'(busy), 32'h1);
		c0 = rg;
		cmd(c, sbp_pkg::OP_ARRAY_READ, 1'b0);
		be = 1'b1;
		repeat (200) if (busy === 1'b1) @(posedge clk);
		pers[b] = 1'b0;
		cmp(rg - c0, 0);
		chk_blk(b);
		cmp(brun, PC);
		// cleared persistent bit protects despite volatile bit at 1
		c0 = wg;
		cmd(b, sbp_pkg::OP_ARRAY_PROG, 1'b0);
		cmp(wg - c0, 0);
		pe = 1'b1;
		cmd(b, sbp_pkg::OP_PERS_READ, 1'b0);
		prd = pers[b];
		chk_st;
		cmd(c, sbp_pkg::OP_PERS_READ, 1'b0);
		prd = pers[c];
		chk_st;
		chk_blk(c);
		// second reset keeps persistent bits
		do_reset;
		chk_blk(b);
		// bulk erase aimed at another block sets them all back to 1
		cmd(c, sbp_pkg::OP_PERS_ERASE, 1'b0);
		repeat (200) if (busy === 1'b1) @(posedge clk);
		foreach (pers[i]) pers[i] = 1'b1;
		chk_blk(b);
		cmp(brun, PC + EC + 1);
		// closed lock refuses persistent changes
		cmd(b, sbp_pkg::OP_LOCK_CLEAR, 1'b0);
		lock = 1'b0;
		cmd(b, sbp_pkg::OP_PERS_PROG, 1'b0);
		cmp(32'(busy), 32'h0);
		cmd(c, sbp_pkg::OP_PERS_ERASE, 1'b0);
		cmp(32'(busy), 32'h0);
		le = 1'b1;
		chk_blk(b);
		cmd(b, sbp_pkg::OP_PERS_READ, 1'b0);
		prd = pers[b];
		chk_st;
		end_of_test;
	end
endmodule : tb_top
